// ===== core/tfs_pkg.sv
package tfs_pkg;
    // Widths of the serial frame and of the register contents
    localparam int DATA_W = 8;
    localparam int ADDR_W = 15;
    localparam int IDX_W = 7;
    localparam int ENTRY_W = 5;
    localparam int LANE_W = 2;
    localparam int LUT_ENTRIES = 32;
    localparam int LUT_WORD_W = 3 * DATA_W;
    localparam int CNT_W = 5;

    // Frame layout: one read/write bit, 15 address bits, 8 data bits
    localparam logic [CNT_W-1:0] TFS_ADDR_LAST_BIT = 5'h0F;
    localparam logic [CNT_W-1:0] TFS_DATA_FIRST_BIT = 5'h10;
    localparam logic [CNT_W-1:0] TFS_FRAME_LAST_BIT = 5'h17;
    localparam logic [CNT_W-1:0] TFS_FRAME_DONE = 5'h18;

    // Register offsets
    localparam logic [ADDR_W-1:0] TFS_OFS_PART_CODE_HIGH = 15'h0005;
    localparam logic [ADDR_W-1:0] TFS_OFS_PART_REVISION = 15'h000C;
    localparam logic [ADDR_W-1:0] TFS_OFS_SEQ_STOP = 15'h0011;
    localparam logic [ADDR_W-1:0] TFS_OFS_SEQ_START = 15'h0012;
    localparam logic [ADDR_W-1:0] TFS_OFS_SEQ_DIR = 15'h0013;
    localparam logic [ADDR_W-1:0] TFS_OFS_SEQ_INDEX = 15'h0014;
    localparam logic [ADDR_W-1:0] TFS_OFS_DIRECT_CENTER = 15'h0020;
    localparam logic [ADDR_W-1:0] TFS_OFS_DIRECT_BW = 15'h0021;
    localparam logic [ADDR_W-1:0] TFS_OFS_DIRECT_MATCH = 15'h0022;
    localparam logic [ADDR_W-1:0] TFS_OFS_TUNING_CONFIG = 15'h0050;
    localparam logic [ADDR_W-1:0] TFS_OFS_APPLIED_CENTER = 15'h0060;
    localparam logic [ADDR_W-1:0] TFS_OFS_LUT_FIRST = 15'h0100;
    localparam logic [ADDR_W-1:0] TFS_OFS_LUT_LAST = 15'h015F;

    // Values after reset
    localparam logic [IDX_W-1:0] TFS_RST_SEQ_STOP = 7'h7F;
    localparam logic [IDX_W-1:0] TFS_RST_SEQ_START = 7'h00;
    localparam logic TFS_RST_SEQ_DIR = 1'b0;
    localparam logic [IDX_W-1:0] TFS_RST_SEQ_INDEX = 7'h00;
    localparam logic [DATA_W-1:0] TFS_RST_CODE = 8'h00;
    localparam logic TFS_RST_DERIVED_EN = 1'b0;

    // Stepping direction of the sequencer
    typedef enum logic {
        TFS_DIR_UP,
        TFS_DIR_DOWN
    } tfs_dir_type;
endpackage

// ===== core/tfs_lut_mem.sv
`timescale 1ns/1ns
module tfs_lut_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Byte write port, lane 0 center, 1 bandwidth, 2 match
    input wire logic wr_en,
    input wire logic [tfs_pkg::ENTRY_W-1:0] wr_entry,
    input wire logic [tfs_pkg::LANE_W-1:0] wr_lane,
    input wire logic [tfs_pkg::DATA_W-1:0] wr_data,
    // Host read port
    input wire logic [tfs_pkg::ENTRY_W-1:0] rd_a_entry,
    output logic [tfs_pkg::LUT_WORD_W-1:0] rd_a_data,
    // Sequencer read port
    input wire logic [tfs_pkg::ENTRY_W-1:0] rd_b_entry,
    output logic [tfs_pkg::LUT_WORD_W-1:0] rd_b_data
);
    import tfs_pkg::*;

    logic [LUT_WORD_W-1:0] mem_reg [LUT_ENTRIES];

    // Entries clear on reset, so it is a flop array rather than a macro
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < LUT_ENTRIES; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (wr_en) begin
            mem_reg[wr_entry][wr_lane*DATA_W +: DATA_W] <= wr_data;
        end
    end

    // Registered reads, one cycle behind the address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_a_data <= '0;
            rd_b_data <= '0;
        end else begin
            rd_a_data <= mem_reg[rd_a_entry];
            rd_b_data <= mem_reg[rd_b_entry];
        end
    end
endmodule

// ===== core/tfs_seq_index.sv
`timescale 1ns/1ns
module tfs_seq_index (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bounds and direction
    input wire logic [tfs_pkg::IDX_W-1:0] start_idx,
    input wire logic [tfs_pkg::IDX_W-1:0] stop_idx,
    input wire tfs_pkg::tfs_dir_type dir,
    // Events
    input wire logic reinit,
    input wire logic advance,
    // Next location to apply
    output logic [tfs_pkg::IDX_W-1:0] index
);
    import tfs_pkg::*;

    // Reload has priority so a fresh setting is never overrun by a step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            index <= TFS_RST_SEQ_INDEX;
        end else if (reinit) begin
            index <= (dir == TFS_DIR_UP) ? start_idx : stop_idx;
        end else if (advance) begin
            if (dir == TFS_DIR_UP) begin
                index <= (index == stop_idx) ? start_idx : index + 7'h01;
            end else begin
                index <= (index == start_idx) ? stop_idx : index - 7'h01;
            end
        end
    end

    property p_reload;
        @(posedge clk) disable iff (rst)
        reinit |=> index == (($past(dir) == TFS_DIR_UP) ? $past(start_idx) : $past(stop_idx));
    endproperty
    a_reload: assert property (p_reload) else $error("index not reloaded");

    property p_step;
        @(posedge clk) disable iff (rst)
        advance && !reinit && dir == TFS_DIR_UP && index != stop_idx
            |=> index == $past(index) + 7'h01;
    endproperty
    a_step: assert property (p_step) else $error("index did not step up");

    property p_wrap;
        @(posedge clk) disable iff (rst)
        advance && !reinit && dir == TFS_DIR_DOWN && index == start_idx
            |=> index == $past(stop_idx);
    endproperty
    a_wrap: assert property (p_wrap) else $error("index did not wrap down");

    property p_hold;
        @(posedge clk) disable iff (rst)
        !advance && !reinit |=> $stable(index);
    endproperty
    a_hold: assert property (p_hold) else $error("index moved without cause");

    c_wrap: cover property (@(posedge clk) disable iff (rst)
        advance && dir == TFS_DIR_UP && index == stop_idx);
endmodule

// ===== core/tfs_top.sv
`timescale 1ns/1ns
// How it works
// - Stop index, seven bits, read/write, resets to 0x7F, upper bound of walk.
// - Start index, seven bits, read/write, resets to zero, lower bound of walk.
// - Direction bit zero selects incrementing, one selects decrementing; resets to zero.
// - Incrementing loads the index with start; decrementing loads it with stop.
// - Index names next entry, applied at chip-select rise in fast-latch mode.
// - Writing start, stop or direction reloads the index.
// - Current index readable as seven bits; writes to it are ignored.
// - Three eight-bit direct codes, center, bandwidth, match, reset to zero.
// - Outside fast-latch mode, derivation enable set makes applied codes come from interpolation, not writes.
// - Applied center code readable in an eight-bit readback, reset zero.
// - Read-only part code high byte and four-bit revision code.
// - Table of 32 entries, three bytes each, from 0x100 to 0x15F.
module tfs_top #(
    parameter logic [7:0] PART_CODE_HIGH = 8'h5A, // Arbitrary value
    parameter logic [3:0] PART_REVISION = 4'h3 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial host port
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Mode select and interpolated codes from the tuning engine
    input wire logic serial_sequenced_latch_mode,
    input wire logic [tfs_pkg::DATA_W-1:0] derived_center_code,
    input wire logic [tfs_pkg::DATA_W-1:0] derived_bandwidth_code,
    input wire logic [tfs_pkg::DATA_W-1:0] derived_match_code,
    // Codes driven to the filter, plus the derivation enable and the current index
    output logic [tfs_pkg::DATA_W-1:0] applied_center_code,
    output logic [tfs_pkg::DATA_W-1:0] applied_bandwidth_code,
    output logic [tfs_pkg::DATA_W-1:0] applied_match_code,
    output logic derived_code_enable,
    output logic [tfs_pkg::IDX_W-1:0] sequence_current_index
);
    import tfs_pkg::*;

    logic sclk_prev_reg;
    logic cs_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [LUT_WORD_W-1:0] shift_in_reg;
    logic rw_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic rd_load_reg;
    logic [DATA_W-1:0] dout_reg;
    logic wr_commit;
    logic [DATA_W-1:0] wr_data;
    logic [IDX_W-1:0] stop_reg;
    logic [IDX_W-1:0] start_reg;
    tfs_dir_type dir_reg;
    logic [IDX_W-1:0] stop_next;
    logic [IDX_W-1:0] start_next;
    tfs_dir_type dir_next;
    logic [ADDR_W-1:0] addr_src;
    logic [DATA_W-1:0] direct_center_reg;
    logic [DATA_W-1:0] direct_bw_reg;
    logic [DATA_W-1:0] direct_match_reg;
    logic seq_reinit;
    logic seq_advance;
    logic lut_hit;
    logic [IDX_W-1:0] lut_off;
    logic [ENTRY_W-1:0] lut_entry;
    logic [LANE_W-1:0] lut_lane;
    logic [LUT_WORD_W-1:0] lut_host_word;
    logic [LUT_WORD_W-1:0] lut_seq_word;
    logic seq_in_table;
    logic [DATA_W-1:0] rd_value;

    // Edge detection; pins are already synchronous to clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk;
            cs_prev_reg <= cs_n;
        end
    end

    assign sclk_rise = !cs_n && sclk && !sclk_prev_reg;
    assign sclk_fall = !cs_n && !sclk && sclk_prev_reg;
    assign cs_rise = cs_n && !cs_prev_reg;

    // Bit counter saturates after one frame; no streaming, extra bits are dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt_reg <= '0;
            shift_in_reg <= '0;
        end else if (cs_n) begin
            bit_cnt_reg <= '0;
        end else if (sclk_rise && bit_cnt_reg != TFS_FRAME_DONE) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            shift_in_reg <= {shift_in_reg[LUT_WORD_W-2:0], sdi};
        end
    end

    // Command and address caught on the sixteenth bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rw_reg <= 1'b0;
            addr_reg <= '0;
            rd_load_reg <= 1'b0;
        end else begin
            rd_load_reg <= 1'b0;
            if (sclk_rise && bit_cnt_reg == TFS_ADDR_LAST_BIT) begin
                rw_reg <= shift_in_reg[ADDR_W-1];
                addr_reg <= {shift_in_reg[ADDR_W-2:0], sdi};
                rd_load_reg <= shift_in_reg[ADDR_W-1];
            end
        end
    end

    assign wr_commit = sclk_rise && bit_cnt_reg == TFS_FRAME_LAST_BIT && !rw_reg;
    assign wr_data = {shift_in_reg[DATA_W-2:0], sdi};

    // Table address split into entry and lane; during capture the port already sees the
    // incoming address, so its registered word is valid when the read data are loaded
    assign addr_src = (sclk_rise && bit_cnt_reg == TFS_ADDR_LAST_BIT)
        ? {shift_in_reg[ADDR_W-2:0], sdi} : addr_reg;
    assign lut_hit = addr_src >= TFS_OFS_LUT_FIRST && addr_src <= TFS_OFS_LUT_LAST;
    assign lut_off = IDX_W'(addr_src - TFS_OFS_LUT_FIRST);
    assign lut_entry = ENTRY_W'(lut_off / 7'h03);
    assign lut_lane = LANE_W'(lut_off % 7'h03);

    // Read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        rd_value = '0;
        case (addr_reg)
            TFS_OFS_PART_CODE_HIGH: rd_value = PART_CODE_HIGH;
            TFS_OFS_PART_REVISION: rd_value = {4'h0, PART_REVISION};
            TFS_OFS_SEQ_STOP: rd_value = {1'b0, stop_reg};
            TFS_OFS_SEQ_START: rd_value = {1'b0, start_reg};
            TFS_OFS_SEQ_DIR: rd_value = {7'h00, dir_reg};
            TFS_OFS_SEQ_INDEX: rd_value = {1'b0, sequence_current_index};
            TFS_OFS_DIRECT_CENTER: rd_value = direct_center_reg;
            TFS_OFS_DIRECT_BW: rd_value = direct_bw_reg;
            TFS_OFS_DIRECT_MATCH: rd_value = direct_match_reg;
            TFS_OFS_TUNING_CONFIG: rd_value = {7'h00, derived_code_enable};
            TFS_OFS_APPLIED_CENTER: rd_value = applied_center_code;
            default: begin
                if (lut_hit) begin
                    rd_value = lut_host_word[lut_lane*DATA_W +: DATA_W];
                end
            end
        endcase
    end

    // Read data loaded once the table port has settled, shifted out on falling sclk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_reg <= '0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (cs_n) begin
            sdo_oe <= 1'b0;
        end else if (rd_load_reg) begin
            dout_reg <= rd_value;
        end else if (sclk_fall && rw_reg && bit_cnt_reg >= TFS_DATA_FIRST_BIT
                     && bit_cnt_reg != TFS_FRAME_DONE) begin
            sdo <= dout_reg[DATA_W-1];
            dout_reg <= {dout_reg[DATA_W-2:0], 1'b0};
            sdo_oe <= 1'b1;
        end
    end

    // Next bounds and direction; the index reloads from these, not the old registers
    assign stop_next = (wr_commit && addr_reg == TFS_OFS_SEQ_STOP)
        ? wr_data[IDX_W-1:0] : stop_reg;
    assign start_next = (wr_commit && addr_reg == TFS_OFS_SEQ_START)
        ? wr_data[IDX_W-1:0] : start_reg;
    assign dir_next = (wr_commit && addr_reg == TFS_OFS_SEQ_DIR)
        ? tfs_dir_type'(wr_data[0]) : dir_reg;

    // Sequencer bounds and direction, seven and one bits wide
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_reg <= TFS_RST_SEQ_STOP;
            start_reg <= TFS_RST_SEQ_START;
            dir_reg <= tfs_dir_type'(TFS_RST_SEQ_DIR);
        end else begin
            stop_reg <= stop_next;
            start_reg <= start_next;
            dir_reg <= dir_next;
        end
    end

    // Direct codes and the derivation enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            direct_center_reg <= TFS_RST_CODE;
            direct_bw_reg <= TFS_RST_CODE;
            direct_match_reg <= TFS_RST_CODE;
            derived_code_enable <= TFS_RST_DERIVED_EN;
        end else if (wr_commit) begin
            case (addr_reg)
                TFS_OFS_DIRECT_CENTER: direct_center_reg <= wr_data;
                TFS_OFS_DIRECT_BW: direct_bw_reg <= wr_data;
                TFS_OFS_DIRECT_MATCH: direct_match_reg <= wr_data;
                TFS_OFS_TUNING_CONFIG: derived_code_enable <= wr_data[0];
                default: begin
                end
            endcase
        end
    end

    // A settings write reloads the index; the reload beats a coincident step
    assign seq_reinit = wr_commit && (addr_reg == TFS_OFS_SEQ_STOP
        || addr_reg == TFS_OFS_SEQ_START || addr_reg == TFS_OFS_SEQ_DIR);
    assign seq_advance = cs_rise && serial_sequenced_latch_mode && !seq_reinit;
    assign seq_in_table = sequence_current_index < IDX_W'(LUT_ENTRIES);

    tfs_seq_index u_seq (
        .clk(clk),
        .rst(rst),
        .start_idx(start_next),
        .stop_idx(stop_next),
        .dir(dir_next),
        .reinit(seq_reinit),
        .advance(seq_advance),
        .index(sequence_current_index)
    );

    tfs_lut_mem u_lut (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_commit && lut_hit),
        .wr_entry(lut_entry),
        .wr_lane(lut_lane),
        .wr_data(wr_data),
        .rd_a_entry(lut_entry),
        .rd_a_data(lut_host_word),
        .rd_b_entry(sequence_current_index[ENTRY_W-1:0]),
        .rd_b_data(lut_seq_word)
    );

    // Applied codes: table entry on each step, else derived or direct codes.
    // Index values past the table apply zeros rather than aliasing an entry.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            applied_center_code <= TFS_RST_CODE;
            applied_bandwidth_code <= TFS_RST_CODE;
            applied_match_code <= TFS_RST_CODE;
        end else if (serial_sequenced_latch_mode) begin
            if (seq_advance) begin
                applied_center_code <= seq_in_table ? lut_seq_word[7:0] : '0;
                applied_bandwidth_code <= seq_in_table ? lut_seq_word[15:8] : '0;
                applied_match_code <= seq_in_table ? lut_seq_word[23:16] : '0;
            end
        end else if (derived_code_enable) begin
            applied_center_code <= derived_center_code;
            applied_bandwidth_code <= derived_bandwidth_code;
            applied_match_code <= derived_match_code;
        end else begin
            applied_center_code <= direct_center_reg;
            applied_bandwidth_code <= direct_bw_reg;
            applied_match_code <= direct_match_reg;
        end
    end

    property p_stop_wr;
        @(posedge clk) disable iff (rst)
        wr_commit && addr_reg == TFS_OFS_SEQ_STOP |=> stop_reg == $past(wr_data[6:0]);
    endproperty
    a_stop_wr: assert property (p_stop_wr) else $error("stop index not written");

    property p_start_wr;
        @(posedge clk) disable iff (rst)
        wr_commit && addr_reg == TFS_OFS_SEQ_START |=> start_reg == $past(wr_data[6:0]);
    endproperty
    a_start_wr: assert property (p_start_wr) else $error("start index not written");

    property p_dir_reload;
        @(posedge clk) disable iff (rst)
        wr_commit && addr_reg == TFS_OFS_SEQ_DIR
            |=> sequence_current_index == ($past(wr_data[0]) ? stop_reg : start_reg);
    endproperty
    a_dir_reload: assert property (p_dir_reload) else $error("direction reload wrong");

    property p_bound_reload;
        @(posedge clk) disable iff (rst)
        wr_commit && addr_reg == TFS_OFS_SEQ_START && dir_reg == TFS_DIR_UP
            |=> sequence_current_index == $past(wr_data[6:0]);
    endproperty
    a_bound_reload: assert property (p_bound_reload) else $error("start reload missed");

    property p_index_ro;
        @(posedge clk) disable iff (rst)
        wr_commit && addr_reg == TFS_OFS_SEQ_INDEX && !seq_advance
            |=> $stable(sequence_current_index);
    endproperty
    a_index_ro: assert property (p_index_ro) else $error("index took a write");

    property p_direct_apply;
        @(posedge clk) disable iff (rst)
        wr_commit && addr_reg == TFS_OFS_DIRECT_CENTER && !serial_sequenced_latch_mode
            && !derived_code_enable
            ##1 !serial_sequenced_latch_mode && !derived_code_enable
            |=> applied_center_code == $past(wr_data, 2);
    endproperty
    a_direct_apply: assert property (p_direct_apply) else $error("direct code not applied");

    property p_derived;
        @(posedge clk) disable iff (rst)
        !serial_sequenced_latch_mode && derived_code_enable
            |=> applied_match_code == $past(derived_match_code);
    endproperty
    a_derived: assert property (p_derived) else $error("derived code not applied");

    property p_seq_apply;
        @(posedge clk) disable iff (rst)
        serial_sequenced_latch_mode && seq_advance && seq_in_table
            |=> applied_bandwidth_code == $past(lut_seq_word[15:8]);
    endproperty
    a_seq_apply: assert property (p_seq_apply) else $error("table entry not applied");

    property p_oe_frame;
        @(posedge clk) disable iff (rst)
        cs_rise |=> !sdo_oe;
    endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("sdo driven after frame");

    c_write: cover property (@(posedge clk) disable iff (rst) wr_commit && lut_hit);
    c_read: cover property (@(posedge clk) disable iff (rst) rd_load_reg && lut_hit);
    c_advance: cover property (@(posedge clk) disable iff (rst) seq_advance);
    c_reload_step: cover property (@(posedge clk) disable iff (rst) seq_reinit && cs_rise);
endmodule

// ===== dv/tfs_host_model.sv
`timescale 1ns/1ns
module tfs_host_model (
    // Clock
    input wire logic clk,
    // Serial lines
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    import tfs_pkg::*;

    // Idle: deselected, clock parked low, it only moves inside frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // Wait a number of clock edges
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One frame: read flag, address, data, msb first; read data taken before each rise
    task automatic xfer(input logic rd, input logic [ADDR_W-1:0] addr,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdat);
        logic [23:0] word;
        word = {rd, addr, wd};
        rdat = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        hold(2);
        for (int i = 23; i >= 0; i--) begin
            if (i < 8) rdat[i] = sdo; // Settled bit from the previous fall
            sdi <= word[i];
            sclk <= 1'b1;
            hold(2);
            sclk <= 1'b0;
            hold(3); // Low phase longer than needed, leaves time for sdo to move
        end
        sdi <= ~word[0]; // Released line must not keep showing the last bit
        cs_n <= 1'b1;
        hold(3);
    endtask

    // Bare select pulse, used to step the sequencer in fast-latch mode
    task automatic pulse();
        @(posedge clk);
        cs_n <= 1'b0;
        hold(2);
        cs_n <= 1'b1;
        hold(3);
    endtask
endmodule

// ===== dv/tfs_top_tb_top.sv
`timescale 1ns/1ns
module tfs_top_tb_top;
    import tfs_pkg::*;
    localparam logic [7:0] PC = 8'h5A; // Arbitrary value
    localparam logic [3:0] PR = 4'h3; // Arbitrary value
    localparam logic [22:0] RST_TAB [11] = '{{TFS_OFS_PART_CODE_HIGH, PC},
        {TFS_OFS_PART_REVISION, 4'h0, PR}, {TFS_OFS_SEQ_STOP, 8'h7F},
        {TFS_OFS_SEQ_START, 8'h00}, {TFS_OFS_SEQ_DIR, 8'h00}, {TFS_OFS_SEQ_INDEX, 8'h00},
        {TFS_OFS_DIRECT_CENTER, 8'h00}, {TFS_OFS_DIRECT_BW, 8'h00},
        {TFS_OFS_DIRECT_MATCH, 8'h00}, {TFS_OFS_TUNING_CONFIG, 8'h00},
        {TFS_OFS_APPLIED_CENTER, 8'h00}};

    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode = 1'b0;
    logic [DATA_W-1:0] d_c = 8'hA1;
    logic [DATA_W-1:0] d_b = 8'hB2;
    logic [DATA_W-1:0] d_m = 8'hC4;
    wire cs_n;
    wire sclk;
    wire sdi;
    logic sdo;
    logic sdo_oe;
    logic [DATA_W-1:0] ap_c;
    logic [DATA_W-1:0] ap_b;
    logic [DATA_W-1:0] ap_m;
    logic der_en;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] rd;
    logic oe_seen = 1'b0;
    int err_count = 0;
    int n_compared = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    // Remembers that the device ever drove its data line during a read
    always @(posedge clk) oe_seen <= oe_seen | sdo_oe;

    tfs_top #(.PART_CODE_HIGH(PC), .PART_REVISION(PR)) u_dut (.clk(clk), .rst(rst),
        .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .serial_sequenced_latch_mode(mode), .derived_center_code(d_c),
        .derived_bandwidth_code(d_b), .derived_match_code(d_m),
        .applied_center_code(ap_c), .applied_bandwidth_code(ap_b),
        .applied_match_code(ap_m), .derived_code_enable(der_en),
        .sequence_current_index(idx));

    tfs_host_model u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

    // Verdict and end of run
    task automatic close_out();
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register access over the serial port
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        u_host.xfer(1'b0, a, d, rd);
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        u_host.xfer(1'b1, a, 8'h00, rd);
        chk(rd, e);
        chk({7'h00, sdo_oe}, 8'h00);
    endtask

    // One sequencer step: applied center code and next index
    task automatic step(input logic [7:0] e_c, input logic [6:0] e_i);
        u_host.pulse();
        chk(ap_c, e_c);
        chk({1'b0, idx}, {1'b0, e_i});
    endtask

    // Mode changes land on a clock edge
    task automatic set_mode(input logic m);
        @(posedge clk);
        mode <= m;
    endtask

    // Hang guard, far beyond the few thousand cycles the tests need
    initial begin
        #2000000;
        err_count++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (RST_TAB[i]) rchk(RST_TAB[i][22:8], RST_TAB[i][7:0]);
        // Reserved bit and read-only places drop writes; an unmapped place reads zero
        wr(TFS_OFS_SEQ_STOP, 8'hFF);
        rchk(TFS_OFS_SEQ_STOP, 8'h7F);
        wr(TFS_OFS_PART_CODE_HIGH, 8'h00);
        rchk(TFS_OFS_PART_CODE_HIGH, PC);
        rchk(15'h0160, 8'h00);
        // Table entries 1 to 3, center code 0x10 + entry
        for (int e = 1; e < 4; e++) wr(TFS_OFS_LUT_FIRST + 15'(3 * e), 8'(8'h10 + e));
        wr(TFS_OFS_LUT_FIRST + 15'h0007, 8'h22);
        wr(TFS_OFS_LUT_FIRST + 15'h0008, 8'h33);
        wr(TFS_OFS_LUT_LAST, 8'hC3);
        rchk(TFS_OFS_LUT_LAST, 8'hC3);
        rchk(TFS_OFS_LUT_FIRST + 15'h0007, 8'h22);
        // Narrow range 1..3 going up; the start write reloads the index
        wr(TFS_OFS_SEQ_STOP, 8'h03);
        wr(TFS_OFS_SEQ_START, 8'h01);
        chk({1'b0, idx}, 8'h01);
        wr(TFS_OFS_SEQ_INDEX, 8'h55);
        rchk(TFS_OFS_SEQ_INDEX, 8'h01);
        set_mode(1'b1);
        step(8'h11, 7'h02);
        step(8'h12, 7'h03);
        chk(ap_b, 8'h22);
        chk(ap_m, 8'h33);
        step(8'h13, 7'h01);
        // Downward walk starts from the stop bound
        set_mode(1'b0);
        wr(TFS_OFS_SEQ_DIR, 8'hFF);
        chk({1'b0, idx}, 8'h03);
        rchk(TFS_OFS_SEQ_DIR, 8'h01);
        set_mode(1'b1);
        step(8'h13, 7'h02);
        step(8'h12, 7'h01);
        step(8'h11, 7'h03);
        // Direct codes programmed by the host itself
        set_mode(1'b0);
        wr(TFS_OFS_DIRECT_CENTER, 8'h3C);
        wr(TFS_OFS_DIRECT_BW, 8'h4D);
        wr(TFS_OFS_DIRECT_MATCH, 8'h5E);
        chk(ap_c, 8'h3C);
        chk(ap_b, 8'h4D);
        chk(ap_m, 8'h5E);
        rchk(TFS_OFS_APPLIED_CENTER, 8'h3C);
        rchk(TFS_OFS_DIRECT_MATCH, 8'h5E);
        // Derived codes take over from the written ones
        wr(TFS_OFS_TUNING_CONFIG, 8'hFF);
        rchk(TFS_OFS_TUNING_CONFIG, 8'h01);
        chk({7'h00, der_en}, 8'h01);
        chk(ap_c, d_c);
        chk(ap_b, d_b);
        chk(ap_m, d_m);
        chk({7'h00, oe_seen}, 8'h01);
        close_out();
    end
endmodule
